/* File: vmlv_cfg.svh */
// offsets, field positions, reset values and vector numbers of the vector map block
`ifndef VMLV_CFG_SVH
`define VMLV_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VMLV_OFF_PWR_CTRL 12'h000
`define VMLV_OFF_RST_STAT 12'h004
`define VMLV_OFF_VECTOR 12'h008
`define VMLV_OFF_IRQ_STAT 12'h00c
`define VMLV_OFF_IRQ_CLR 12'h010
`define VMLV_OFF_IRQ_EN 12'h014
// ----------------------------------------------------------------
// power_mgmt_ctrl_one fields
// ----------------------------------------------------------------
`define VMLV_PC_DET_EN 0
`define VMLV_PC_STOP_EN 1
`define VMLV_PC_RST_EN 2
`define VMLV_PC_THR_SEL 3
`define VMLV_PC_WARN_IE 4
`define VMLV_PC_WDOG_SEL 5
`define VMLV_PC_RESET 6'h07
// ----------------------------------------------------------------
// reset_source_status fields
// ----------------------------------------------------------------
`define VMLV_RS_POR 7
`define VMLV_RS_PIN 6
`define VMLV_RS_WDOG 5
`define VMLV_RS_BAD_OP 4
`define VMLV_RS_BAD_ADDR 3
`define VMLV_RS_LV 1
`define VMLV_RS_RESET 8'h82
// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define VMLV_IS_WARN 0
`define VMLV_IS_STOP_REF 1
// ----------------------------------------------------------------
// vector numbers and addresses
// ----------------------------------------------------------------
`define VMLV_VEC_RESET 5'h00
`define VMLV_VEC_WARN 5'h03
`define VMLV_VEC_TMR_LO 5'h05
`define VMLV_VEC_SPI 5'h0f
`define VMLV_VEC_SCI_ERR 5'h10
`define VMLV_VEC_TOP_ADDR 16'hfffe
`define VMLV_VEC_NONE 5'h1f
`endif

/* File: vmlv_pkg.sv */
// types of the vector map and low-voltage control block
package vmlv_pkg;
  typedef enum logic [3:0] {
    VMLV_ST_POR_HOLD = 4'h1,
    VMLV_ST_RUN = 4'h2,
    VMLV_ST_RST_HOLD = 4'h4,
    VMLV_ST_STOP = 4'h8
  } vmlv_state_t;

  typedef enum logic [1:0] {
    VMLV_STOP_NONE = 2'h0,
    VMLV_STOP_MID = 2'h1,
    VMLV_STOP_DEEP = 2'h2
  } vmlv_stop_t;

  // peripheral requests with their local enables
  typedef struct packed {
    logic [3:0] sci_err_flag;
    logic [3:0] sci_err_en;
    logic [2:0] spi_flag;
    logic [2:0] spi_en;
    logic [9:0] tmr_flag;
    logic [9:0] tmr_en;
  } vmlv_periph_t;

  // reset sources sampled on the bus clock
  typedef struct packed {
    logic wdog_timeout;
    logic reset_pin;
    logic illegal_opcode;
    logic illegal_address;
  } vmlv_rst_src_t;

  // supply comparator results from the analog detector
  typedef struct packed {
    logic below_low;
    logic below_high;
    logic warn;
  } vmlv_supply_t;

  // complete block state
  typedef struct packed {
    vmlv_state_t state;
    vmlv_stop_t stop_mode;
    logic lv_rst_hold;
    logic [5:0] pwr_ctrl;
    logic [7:0] rst_stat;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [4:0] vec_num;
    logic [15:0] vec_addr;
    logic vec_valid;
    logic sys_reset;
    logic det_on;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vmlv_regs_t;
endpackage

/* File: vmlv_ctrl.sv */
// vector map and low-voltage detect control with APB register access
`include "vmlv_cfg.svh"

module vmlv_ctrl
  import vmlv_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests and reset sources
  input wire vmlv_periph_t periph,
  input wire vmlv_rst_src_t rst_src,
  input wire vmlv_supply_t supply,
  // stop mode request and wake
  input wire logic stop_req,
  input wire logic stop_deep,
  input wire logic wake,
  // outputs to the core
  output logic sys_reset,
  output logic detector_on,
  output logic [1:0] stop_mode,
  output logic vec_valid,
  output logic [4:0] vec_num,
  output logic [15:0] vec_addr,
  output logic irq
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // lowest pending vector number, or none
  function automatic logic [4:0] vmlv_pick(input logic [31:0] pend);
    logic [4:0] n;
    n = `VMLV_VEC_NONE;
    for (int i = 31; i >= 0; i--) begin
      if (pend[i]) begin
        n = 5'(i);
      end
    end
    return n;
  endfunction

  // vector address of a vector number, two bytes per vector downward
  function automatic logic [15:0] vmlv_addr(input logic [4:0] n);
    return `VMLV_VEC_TOP_ADDR - {10'h000, n, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  vmlv_regs_t r_r;
  vmlv_regs_t r_nxt;
  logic acc;
  logic wr;
  logic rd_hit;
  logic [31:0] pend;
  logic det_act;
  logic lv_trip;
  logic wdog_rst;
  logic lv_rst;
  logic ext_rst;
  logic refuse_deep;
  logic [5:0] pc;
  logic [1:0] clr;
  logic [31:0] rdata;

  assign acc = psel && penable && !r_r.pready;
  assign wr = psel && penable && r_r.pready && pwrite;
  assign pc = r_r.pwr_ctrl;

  // request map: vector 3, timers 5..14, spi 15, sci errors 16
  always_comb begin
    pend = 32'h0000_0000;
    pend[`VMLV_VEC_WARN] = r_r.irq_stat[`VMLV_IS_WARN] && pc[`VMLV_PC_WARN_IE];
    for (int i = 0; i < 10; i++) begin
      pend[int'(`VMLV_VEC_TMR_LO) + i] = periph.tmr_flag[i] && periph.tmr_en[i];
    end
    pend[`VMLV_VEC_SPI] = |(periph.spi_flag & periph.spi_en);
    pend[`VMLV_VEC_SCI_ERR] = |(periph.sci_err_flag & periph.sci_err_en);
  end

  // detector activity, trip point and reset sources
  always_comb begin
    det_act = pc[`VMLV_PC_DET_EN];
    if (r_r.state == VMLV_ST_STOP && !pc[`VMLV_PC_STOP_EN]) begin
      det_act = 1'b0;
    end
    lv_trip = pc[`VMLV_PC_THR_SEL] ? supply.below_high : supply.below_low;
    lv_rst = det_act && pc[`VMLV_PC_RST_EN] && lv_trip;
    wdog_rst = rst_src.wdog_timeout && pc[`VMLV_PC_WDOG_SEL];
    ext_rst = rst_src.reset_pin || rst_src.illegal_opcode || rst_src.illegal_address;
    refuse_deep = pc[`VMLV_PC_DET_EN] && pc[`VMLV_PC_STOP_EN];
  end

  // register read mux
  always_comb begin
    rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `VMLV_OFF_PWR_CTRL: rdata = {26'h0, pc};
      `VMLV_OFF_RST_STAT: rdata = {24'h0, r_r.rst_stat};
      `VMLV_OFF_VECTOR: rdata = {r_r.vec_addr, 10'h0, r_r.vec_valid, r_r.vec_num};
      `VMLV_OFF_IRQ_STAT: rdata = {30'h0, r_r.irq_stat};
      `VMLV_OFF_IRQ_CLR: rdata = 32'h0000_0000;
      `VMLV_OFF_IRQ_EN: rdata = {30'h0, r_r.irq_en};
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    clr = 2'h0;
    // apb: one wait cycle, then answer
    r_nxt.pready = acc;
    r_nxt.pslverr = acc && !rd_hit;
    if (acc) begin
      r_nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
    end
    if (wr && paddr == `VMLV_OFF_PWR_CTRL) begin
      r_nxt.pwr_ctrl = pwdata[5:0];
    end
    if (wr && paddr == `VMLV_OFF_IRQ_EN) begin
      r_nxt.irq_en = pwdata[1:0];
    end
    if (wr && paddr == `VMLV_OFF_IRQ_CLR) begin
      clr = pwdata[1:0];
    end
    // sticky flags: set wins over clear
    r_nxt.irq_stat = r_r.irq_stat & ~clr;
    if (det_act && supply.warn && pc[`VMLV_PC_WARN_IE]) begin
      r_nxt.irq_stat[`VMLV_IS_WARN] = 1'b1;
    end
    if (r_r.state == VMLV_ST_RUN && stop_req && stop_deep && refuse_deep) begin
      r_nxt.irq_stat[`VMLV_IS_STOP_REF] = 1'b1;
    end
    case (r_r.state)
      VMLV_ST_POR_HOLD: begin
        r_nxt.sys_reset = 1'b1;
        if (!supply.below_low) begin
          r_nxt.state = VMLV_ST_RUN;
          r_nxt.sys_reset = 1'b0;
        end
      end
      VMLV_ST_RUN: begin
        if (lv_rst || wdog_rst || ext_rst) begin
          r_nxt.state = VMLV_ST_RST_HOLD;
          r_nxt.sys_reset = 1'b1;
          r_nxt.lv_rst_hold = lv_rst;
          r_nxt.rst_stat = 8'h00;
          r_nxt.rst_stat[`VMLV_RS_POR] = lv_rst && r_r.rst_stat[`VMLV_RS_POR];
          r_nxt.rst_stat[`VMLV_RS_PIN] = rst_src.reset_pin;
          r_nxt.rst_stat[`VMLV_RS_WDOG] = wdog_rst;
          r_nxt.rst_stat[`VMLV_RS_BAD_OP] = rst_src.illegal_opcode;
          r_nxt.rst_stat[`VMLV_RS_BAD_ADDR] = rst_src.illegal_address;
          r_nxt.rst_stat[`VMLV_RS_LV] = lv_rst;
          r_nxt.pwr_ctrl = `VMLV_PC_RESET;
          r_nxt.pwr_ctrl[`VMLV_PC_THR_SEL] = pc[`VMLV_PC_THR_SEL]; // hold uses tripped point
          r_nxt.irq_stat = 2'h0;
          r_nxt.irq_en = 2'h0;
        end else if (stop_req) begin
          r_nxt.state = VMLV_ST_STOP;
          r_nxt.stop_mode = (stop_deep && !refuse_deep) ? VMLV_STOP_DEEP
                                                        : VMLV_STOP_MID;
        end
      end
      VMLV_ST_RST_HOLD: begin
        if (!r_r.lv_rst_hold || !lv_trip) begin
          r_nxt.state = VMLV_ST_RUN;
          r_nxt.sys_reset = 1'b0;
          r_nxt.lv_rst_hold = 1'b0;
        end
      end
      VMLV_ST_STOP: begin
        if (lv_rst) begin
          r_nxt.state = VMLV_ST_RUN;
          r_nxt.stop_mode = VMLV_STOP_NONE;
        end else if (wake) begin
          r_nxt.state = VMLV_ST_RUN;
          r_nxt.stop_mode = VMLV_STOP_NONE;
        end
      end
      default: begin
        r_nxt.state = VMLV_ST_POR_HOLD;
        r_nxt.sys_reset = 1'b1;
      end
    endcase
    r_nxt.det_on = det_act;
    // vector selection, lowest number first
    r_nxt.vec_num = vmlv_pick(pend);
    r_nxt.vec_valid = |pend;
    r_nxt.vec_addr = r_nxt.vec_valid ? vmlv_addr(r_nxt.vec_num) : `VMLV_VEC_TOP_ADDR;
    if (r_nxt.sys_reset) begin
      r_nxt.vec_num = `VMLV_VEC_RESET;
      r_nxt.vec_valid = 1'b1;
      r_nxt.vec_addr = `VMLV_VEC_TOP_ADDR;
    end
    r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_en);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.state <= VMLV_ST_POR_HOLD;
      r_r.stop_mode <= VMLV_STOP_NONE;
      r_r.pwr_ctrl <= `VMLV_PC_RESET;
      r_r.rst_stat <= `VMLV_RS_RESET;
      r_r.sys_reset <= 1'b1;
      r_r.vec_valid <= 1'b1;
      r_r.vec_addr <= `VMLV_VEC_TOP_ADDR;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign sys_reset = r_r.sys_reset;
  assign detector_on = r_r.det_on;
  assign stop_mode = r_r.stop_mode;
  assign vec_valid = r_r.vec_valid;
  assign vec_num = r_r.vec_num;
  assign vec_addr = r_r.vec_addr;
  assign irq = r_r.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reset_vector: assert property (@(posedge pclk) disable iff (!presetn)
    sys_reset |-> (vec_num == 5'h00 && vec_addr == 16'hfffe))
    else $error("reset vector not selected");

  a_sci_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (!sys_reset && (|(periph.sci_err_flag & periph.sci_err_en)) && pend[15:0] == 16'h0)
      |=> (sys_reset || (vec_num == 5'h10 && vec_addr == 16'hffde && vec_valid)))
    else $error("sci error vector wrong");

  a_det_off: assert property (@(posedge pclk) disable iff (!presetn)
    !r_r.pwr_ctrl[0] |=> !detector_on)
    else $error("detector on while disabled");

  a_stop_det: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_STOP && !r_r.pwr_ctrl[1]) |=> !detector_on)
    else $error("detector on in stop");

  a_deep_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && stop_req && !lv_rst && !wdog_rst && !ext_rst
      && r_r.pwr_ctrl[1:0] == 2'h3) |=> stop_mode == VMLV_STOP_MID)
    else $error("deep stop entered with detector kept");

  a_por_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_POR_HOLD && supply.below_low) |=> sys_reset)
    else $error("reset released below low threshold");

  a_lv_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && lv_rst) |=> (sys_reset && r_r.rst_stat[1]))
    else $error("low voltage reset missed");

  a_lv_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RST_HOLD && r_r.lv_rst_hold && lv_trip) |=> sys_reset)
    else $error("lv reset released early");

  a_warn_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (det_act && supply.warn && r_r.pwr_ctrl[4]
      && !(r_r.state == VMLV_ST_RUN && (lv_rst || wdog_rst || ext_rst)))
      |=> r_r.irq_stat[0])
    else $error("warning flag not set");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(r_r.irq_stat & r_r.irq_en))
    else $error("irq level mismatch");

  a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && rst_src.reset_pin)
      |=> (sys_reset && vec_num == 5'h00 && r_r.rst_stat[6]))
    else $error("reset pin not taken");

  a_wdog_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && rst_src.wdog_timeout && !r_r.pwr_ctrl[5]
      && !lv_rst && !ext_rst) |=> !sys_reset)
    else $error("watchdog reset not gated");

  a_lv_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && !r_r.pwr_ctrl[2] && !wdog_rst && !ext_rst) |=> !sys_reset)
    else $error("low voltage reset not gated");

  a_high_trip: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && r_r.pwr_ctrl[3:2] == 2'h3 && r_r.pwr_ctrl[0]
      && supply.below_high) |=> sys_reset)
    else $error("high trip point ignored");

  a_low_trip: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_RUN && !r_r.pwr_ctrl[3] && !supply.below_low && !wdog_rst
      && !ext_rst) |=> !sys_reset)
    else $error("reset above low trip point");

  a_por_status: assert property (@(posedge pclk) disable iff (!presetn)
    r_r.state == VMLV_ST_POR_HOLD |-> (r_r.rst_stat[7] && r_r.rst_stat[1]))
    else $error("power-on status bits missing");

  a_timer_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (periph.tmr_flag[0] && periph.tmr_en[0] && pend[4:0] == 5'h00)
      |=> (sys_reset || (vec_num == 5'h05 && vec_addr == 16'hfff4)))
    else $error("timer vector wrong");

  a_spi_vector: assert property (@(posedge pclk) disable iff (!presetn)
    ((|(periph.spi_flag & periph.spi_en)) && pend[14:0] == 15'h0000)
      |=> (sys_reset || (vec_num == 5'h0f && vec_addr == 16'hffe0)))
    else $error("spi vector wrong");

  a_warn_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.irq_stat[0] && r_r.pwr_ctrl[4])
      |=> (sys_reset || (vec_num == 5'h03 && vec_addr == 16'hfff8)))
    else $error("warning vector wrong");

  a_lowest_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (pend[16] && (|pend[15:3])) |=> (sys_reset || vec_num != 5'h10))
    else $error("lower vector lost priority");

  a_stop_det_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (r_r.state == VMLV_ST_STOP && r_r.pwr_ctrl[1:0] == 2'h3) |=> detector_on)
    else $error("detector off in stop with stop enable");
endmodule

/* File: vmlv_ctrl_tb.sv */
// self-checking testbench of the vector map and low-voltage control block
`include "vmlv_cfg.svh"

module vmlv_ctrl_tb
  import vmlv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  vmlv_periph_t periph = '0;
  vmlv_rst_src_t rst_src = '0;
  vmlv_supply_t supply = 3'h4;
  logic stop_req = 1'b0;
  logic stop_deep = 1'b0;
  logic wake = 1'b0;
  logic sys_reset;
  logic detector_on;
  logic [1:0] stop_mode;
  logic vec_valid;
  logic [4:0] vec_num;
  logic [15:0] vec_addr;
  logic irq;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  // 100 mhz bus clock
  always #5 pclk = ~pclk;

  vmlv_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph(periph), .rst_src(rst_src), .supply(supply),
    .stop_req(stop_req), .stop_deep(stop_deep), .wake(wake), .sys_reset(sys_reset),
    .detector_on(detector_on), .stop_mode(stop_mode), .vec_valid(vec_valid),
    .vec_num(vec_num), .vec_addr(vec_addr), .irq(irq));

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  task automatic vchk(input logic [4:0] n);
    tick(3);
    chk("vec_num", {27'h0, vec_num}, {27'h0, n});
    chk("vec_addr", {16'h0, vec_addr}, 32'h0000fffe - {26'h0, n, 1'b0});
    chk("vec_valid", {31'h0, vec_valid}, 32'h1);
  endtask

  // pulse one reset source; stat of zero means the source must be ignored
  task automatic src_rst(input logic [3:0] s, input logic [31:0] stat);
    @(posedge pclk);
    rst_src <= s;
    @(posedge pclk);
    rst_src <= 4'h0;
    @(negedge pclk);
    chk("sys_reset", {31'h0, sys_reset}, {31'h0, stat != 32'h0});
    tick(4);
    chk("sys_reset off", {31'h0, sys_reset}, 32'h0);
    if (stat != 32'h0) begin
      rchk(`VMLV_OFF_RST_STAT, stat, "rst_stat");
    end
  endtask

  task automatic stop_chk(input logic dp, input logic [1:0] m, input logic d);
    @(posedge pclk);
    stop_req <= 1'b1;
    stop_deep <= dp;
    @(posedge pclk);
    stop_req <= 1'b0;
    tick(2);
    chk("stop_mode", {30'h0, stop_mode}, {30'h0, m});
    chk("detector_on", {31'h0, detector_on}, {31'h0, d});
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(2);
    chk("stop_mode run", {30'h0, stop_mode}, 32'h0);
  endtask

  // cut a hang short
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(5);
    chk("por hold", {31'h0, sys_reset}, 32'h1);
    rchk(`VMLV_OFF_RST_STAT, 32'h82, "por status");
    rchk(`VMLV_OFF_PWR_CTRL, 32'h07, "ctrl reset");
    supply <= 3'h0;
    tick(3);
    chk("por release", {31'h0, sys_reset}, 32'h0);
    apb(1'b1, `VMLV_OFF_RST_STAT, 32'hffffffff);
    rchk(`VMLV_OFF_RST_STAT, 32'h82, "ro status");
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    // each peripheral request on its own
    for (int i = 0; i < 17; i++) begin
      logic [9:0] b;
      b = 10'(1 << (i < 4 ? i : i < 7 ? i - 4 : i - 7));
      periph <= i < 4 ? {b[3:0], b[3:0], 26'h0} :
        i < 7 ? {8'h0, b[2:0], b[2:0], 20'h0} : {14'h0, b, b};
      vchk(5'(i < 4 ? 16 : i < 7 ? 15 : i - 2));
    end
    periph <= {4'hf, 4'hf, 3'h7, 3'h7, 10'h3fe, 10'h3fe};
    vchk(5'h06);
    periph <= {4'hf, 4'hf, 3'h7, 3'h7, 10'h3fe, 10'h000};
    vchk(5'h0f);
    // low-voltage warning beats the pending spi and sci error requests
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h11);
    apb(1'b1, `VMLV_OFF_IRQ_EN, 32'h1);
    supply <= 3'h1;
    tick(3);
    supply <= 3'h0;
    rchk(`VMLV_OFF_IRQ_STAT, 32'h1, "warn flag");
    chk("irq", {31'h0, irq}, 32'h1);
    vchk(5'h03);
    apb(1'b1, `VMLV_OFF_IRQ_EN, 32'h0);
    tick(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `VMLV_OFF_IRQ_EN, 32'h1);
    apb(1'b1, `VMLV_OFF_IRQ_CLR, 32'h1);
    tick(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rchk(`VMLV_OFF_IRQ_STAT, 32'h0, "stat cleared");
    periph <= '0;
    // reset sources
    src_rst(4'h8, 32'h0);
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h27);
    src_rst(4'h8, 32'h20);
    src_rst(4'h4, 32'h40);
    src_rst(4'h2, 32'h10);
    src_rst(4'h1, 32'h08);
    // low-voltage reset holds while supply stays low
    supply <= 3'h4;
    tick(10);
    chk("lv reset", {31'h0, sys_reset}, 32'h1);
    chk("lv vector", {11'h0, vec_num, vec_addr}, 32'h0000fffe);
    supply <= 3'h0;
    tick(3);
    chk("lv release", {31'h0, sys_reset}, 32'h0);
    rchk(`VMLV_OFF_RST_STAT, 32'h02, "lv status");
    // trip point follows the threshold select
    supply <= 3'h2;
    tick(5);
    chk("low trip", {31'h0, sys_reset}, 32'h0);
    supply <= 3'h0;
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h0f);
    supply <= 3'h2;
    tick(3);
    chk("high trip", {31'h0, sys_reset}, 32'h1);
    supply <= 3'h0;
    tick(5);
    // detector off ignores low supply
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h06);
    tick(2);
    chk("det off", {31'h0, detector_on}, 32'h0);
    supply <= 3'h4;
    tick(5);
    chk("no lv reset", {31'h0, sys_reset}, 32'h0);
    supply <= 3'h0;
    // stop entry with and without the stop enable
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h01);
    tick(2);
    chk("det on", {31'h0, detector_on}, 32'h1);
    supply <= 3'h4;
    tick(3);
    chk("lv gated", {31'h0, sys_reset}, 32'h0);
    supply <= 3'h0;
    stop_chk(1'b0, 2'h1, 1'b0);
    stop_chk(1'b1, 2'h2, 1'b0);
    apb(1'b1, `VMLV_OFF_PWR_CTRL, 32'h03);
    stop_chk(1'b1, 2'h1, 1'b1);
    rchk(`VMLV_OFF_IRQ_STAT, 32'h2, "deep refused");
    wrap_up();
  end
endmodule
